//--- pkg/mrsc_pkg.sv
/*
  Shared constants for the motor run/stop/speed command logic: clock rate,
  speed limits, knob scaling, filter and ramp timing, input slots, states.
  Assumes a single 20 MHz clock and knob/analogue values already digitised.
*/
package mrsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_KHZ = CLK_HZ / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // Speed figures in r/min
  localparam int SPD_W = 12;
  localparam logic [11:0] SPD_MIN = 12'h064;    // 100 r/min
  localparam logic [11:0] SPD_MAX = 12'hFA0;    // 4000 r/min
  localparam logic [31:0] SPD_RATED = 32'h0000_0BB8;  // 3000 r/min per ramp time

  ////////////////////////////////////////////////////////////////////////////
  // Knob scaling, 8-bit knob codes
  localparam logic [7:0] RAMP_MIN_T = 8'h02;    // 0.2 s in tenths
  localparam logic [7:0] RAMP_MAX_T = 8'h96;    // 15 s in tenths
  localparam logic [7:0] RAMP_SCALE = 8'h95;    // code*149>>8 spans 0..148
  localparam logic [7:0] TRQ_SCALE = 8'hC9;     // code*201>>8 spans 0..200
  localparam logic [7:0] TRQ_MAX = 8'hC8;       // 200 percent
  localparam logic [7:0] TRQ_RST = 8'hC8;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: input filter and ramp time unit
  localparam int DEB_MS = 5;
  localparam int DEB_CYC = DEB_MS * CLK_KHZ;
  localparam int RAMP_UNIT_MS = 100;
  localparam int RAMP_UNIT_CYC = RAMP_UNIT_MS * CLK_KHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Filtered input slots
  localparam int IN_FWD = 0;
  localparam int IN_REV = 1;
  localparam int IN_STOP = 2;
  localparam int IN_SRC = 3;
  localparam int N_IN = 4;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN = 3'b010,
    S_DECEL = 3'b100
  } mrsc_state_e;

endpackage

//--- verilog/mrsc_debounce.sv
/*
  Two-flop synchroniser and stability filter for one run/select input.
  Assumes the input is a slow level held for longer than the filter period.
*/
`timescale 1ns/1ns
module mrsc_debounce #(
  parameter int CYC = 100000
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic raw_i,
  output logic level_o
);
  import mrsc_pkg::*;

  localparam int CNT_W = $clog2(CYC + 1);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic level;
    logic [CNT_W-1:0] cnt;
  } mrsc_deb_s;

  mrsc_deb_s s_r;
  mrsc_deb_s s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Level is only taken after it held for CYC cycles; glitches restart count
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = raw_i;
    s_nxt.sync2 = s_r.sync1;
    if (s_r.sync2 == s_r.level) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == CNT_W'(CYC - 1)) begin
      s_nxt.level = s_r.sync2;  // R21
      s_nxt.cnt = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_o = s_r.level;

  a_level_cause: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // R21
    $changed(s_r.level) |-> $past(s_r.sync2) == s_r.level && $past(s_r.sync2, 2) == s_r.level)
    else $error("filtered level changed without a stable input");

endmodule

//--- verilog/mrsc_top.sv
/*
  Run/stop and speed reference logic of a brushless motor driver: filters
  run and select inputs, picks the speed source, ramps the speed reference,
  scales torque limit and latches the response mode at power-up.
  Assumes knob and analogue values arrive as codes synchronous to mclk_i;
  the commutation stage downstream follows speed_ref_o and dir_cw_o.
*/
`timescale 1ns/1ns

// Summary of operation
// [R1] Speed command is zero or 100 to 4000 r/min.
// [R2] Internal knob raises speed clockwise; zero code commands zero speed.
// [R3] Source select high takes analogue input, low takes internal knob.
// [R4] Range switch off scales analogue as 0-5 V, on as 0-10 V.
// [R5] Forward alone runs clockwise with ramp; release stops the motor.
// [R6] Reverse alone runs counterclockwise with ramp; release stops the motor.
// [R7] Forward and reverse together stop instantly regardless of stop style.
// [R8] On release, stop style high ramps down, low stops instantly.
// [R9] Ramp knob sets 0.2 to 15 s, longer clockwise, for all sources.
// [R10] Ramp time means 0 to 3000 r/min or back, fixing slope.
// [R11] Acceleration and deceleration share one ramp time.
// [R12] Response switch on selects fast tracking, off slow regenerative-safe.
// [R13] Response switch is sampled only at power-up.
// [R14] Controller holds each input on and off at least 10 ms.
// [R15] Controller leaves 10 ms gap between forward and reverse.
// [R16] Torque limit from knob, 0 to 200 percent, default 200.
// [R17] Polarity switch selects sink (off, default) or source input sense.
// [R18] Stored direction setting swaps rotation for forward and reverse.
// [R19] Controller asserts stop style before stopping a braked vertical load.
// [R20] Range switch must be off with an external speed knob.
// [R21] Inputs synchronised and filtered, shorter than 10 ms.
// [R22] Ramp is linear at 3000 r/min per ramp time, saturating exactly.
module mrsc_top
  import mrsc_pkg::*;
#(
  parameter int DEB_CYCLES = mrsc_pkg::DEB_CYC,
  parameter int RAMP_UNIT_CYCLES = mrsc_pkg::RAMP_UNIT_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic forward_run_i,
  input wire logic reverse_run_i,
  input wire logic stop_style_select_i,
  input wire logic speed_source_select_i,
  input wire logic input_polarity_switch_i,
  input wire logic analog_range_switch_i,
  input wire logic response_mode_switch_i,
  input wire logic dir_swap_i,
  input wire logic [mrsc_pkg::SPD_W-1:0] internal_speed_knob_i,
  input wire logic [mrsc_pkg::SPD_W-1:0] analog_speed_in_i,
  input wire logic [7:0] ramp_time_knob_i,
  input wire logic [7:0] torque_limit_knob_i,
  output logic [mrsc_pkg::SPD_W-1:0] speed_ref_o,
  output logic dir_cw_o,
  output logic motor_enable_o,
  output logic response_fast_o,
  output logic [7:0] torque_limit_pct_o
);
  import mrsc_pkg::*;

  typedef struct packed {
    mrsc_state_e fsm;
    logic [SPD_W-1:0] spd;
    logic [SPD_W-1:0] tgt;
    logic dir_cw;
    logic en;
    logic [31:0] acc;
    logic [7:0] ramp_t;
    logic [7:0] trq;
    logic resp_fast;
    logic resp_done;
  } mrsc_top_s;

  localparam mrsc_top_s RST_S = '{
    fsm: S_IDLE, spd: '0, tgt: '0, dir_cw: 1'b0, en: 1'b0, acc: '0,
    ramp_t: RAMP_MIN_T, trq: TRQ_RST, resp_fast: 1'b0, resp_done: 1'b0
  };

  mrsc_top_s s_r;
  mrsc_top_s s_nxt;

  logic [N_IN-1:0] pin_raw;
  logic [N_IN-1:0] pin_q;
  logic fwd_q;
  logic rev_q;
  logic stop_q;
  logic src_q;
  logic [SPD_W-1:0] int_spd;
  logic [SPD_W-1:0] ext_spd;
  logic [31:0] ramp_den;
  logic [31:0] acc_sum;
  logic step_w;
  logic one_run;
  logic both_run;
  logic req_cw;
  logic same_dir;

  ////////////////////////////////////////////////////////////////////////////
  // Input filtering

  // Source-style wiring inverts the sensed level before filtering
  assign pin_raw[IN_FWD] = forward_run_i ^ input_polarity_switch_i;  // R17
  assign pin_raw[IN_REV] = reverse_run_i ^ input_polarity_switch_i;
  assign pin_raw[IN_STOP] = stop_style_select_i ^ input_polarity_switch_i;
  assign pin_raw[IN_SRC] = speed_source_select_i ^ input_polarity_switch_i;

  // One filter per input; relies on the controller's 10 ms hold times
  for (genvar i = 0; i < N_IN; i++) begin : g_filt
    mrsc_debounce #(
      .CYC(DEB_CYCLES)
    ) u_filt (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .raw_i(pin_raw[i]),
      .level_o(pin_q[i])
    );  // R21 R14
  end

  assign fwd_q = pin_q[IN_FWD];
  assign rev_q = pin_q[IN_REV];
  assign stop_q = pin_q[IN_STOP];
  assign src_q = pin_q[IN_SRC];

  ////////////////////////////////////////////////////////////////////////////
  // Speed sources

  // Clip to 4000 and drop anything below 100 to a zero command
  function automatic logic [SPD_W-1:0] clip_speed(input logic [SPD_W:0] v);
    logic [SPD_W-1:0] r;
    r = (v > {1'b0, SPD_MAX}) ? SPD_MAX : v[SPD_W-1:0];
    if (r < SPD_MIN) begin
      r = '0;
    end
    return r;
  endfunction

  // Knob code is the speed itself, so zero code gives a stop
  assign int_spd = clip_speed({1'b0, internal_speed_knob_i});  // R1 R2
  // Analogue code spans 0-10 V; the 5 V range doubles it
  assign ext_spd = analog_range_switch_i ?
    clip_speed({1'b0, analog_speed_in_i}) :
    clip_speed({analog_speed_in_i, 1'b0});  // R4

  ////////////////////////////////////////////////////////////////////////////
  // Ramp pacing: 3000 added per cycle, one r/min per ramp_t*unit crossing.
  // Error-free slope without a divider; step never exceeds one per cycle.
  assign ramp_den = 32'(s_r.ramp_t) * 32'(RAMP_UNIT_CYCLES);  // R10 R11
  assign acc_sum = s_r.acc + SPD_RATED;
  assign step_w = (acc_sum >= ramp_den);  // R22

  assign one_run = fwd_q ^ rev_q;
  assign both_run = fwd_q & rev_q;
  assign req_cw = fwd_q ^ dir_swap_i;  // R18
  assign same_dir = one_run && (req_cw == s_r.dir_cw);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.tgt = src_q ? ext_spd : int_spd;  // R3
    // Shorter knob code means shorter ramp
    s_nxt.ramp_t = RAMP_MIN_T + 8'((16'(ramp_time_knob_i) * 16'(RAMP_SCALE)) >> 8);  // R9
    s_nxt.trq = 8'((16'(torque_limit_knob_i) * 16'(TRQ_SCALE)) >> 8);  // R16
    // Only the first cycle after reset looks at the switch
    if (!s_r.resp_done) begin
      s_nxt.resp_fast = response_mode_switch_i;  // R12 R13
      s_nxt.resp_done = 1'b1;
    end
    s_nxt.acc = step_w ? (acc_sum - ramp_den) : acc_sum;
    // Knob turned shorter mid-ramp: drop the excess so steps never chain
    if (step_w && (acc_sum - ramp_den >= ramp_den)) begin
      s_nxt.acc = '0;  // R22
    end
    case (s_r.fsm)
      S_IDLE: begin
        s_nxt.spd = '0;
        s_nxt.acc = '0;
        if (one_run) begin
          s_nxt.fsm = S_RUN;
          s_nxt.dir_cw = req_cw;  // R5 R6
        end
      end
      S_RUN: begin
        if (same_dir) begin
          // Same slope both ways, saturating on the target
          if (step_w && s_r.spd < s_r.tgt) begin
            s_nxt.spd = s_r.spd + 12'h001;  // R5 R6 R11 R22
          end else if (step_w && s_r.spd > s_r.tgt) begin
            s_nxt.spd = s_r.spd - 12'h001;  // R22
          end
        end else if (stop_q) begin
          s_nxt.fsm = S_DECEL;  // R8 R19
        end else begin
          s_nxt.fsm = S_IDLE;  // R8
          s_nxt.spd = '0;
        end
      end
      S_DECEL: begin
        if (same_dir) begin
          s_nxt.fsm = S_RUN;
        end else if (s_r.spd == '0) begin
          s_nxt.fsm = S_IDLE;  // R22
        end else if (step_w) begin
          s_nxt.spd = s_r.spd - 12'h001;  // R8 R11
        end
      end
      default: begin
        s_nxt.fsm = S_IDLE;
        s_nxt.spd = '0;
      end
    endcase
    // Both run inputs override everything, stop style included
    if (both_run) begin
      s_nxt.fsm = S_IDLE;  // R7
      s_nxt.spd = '0;
    end
    s_nxt.en = (s_nxt.fsm != S_IDLE);
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s_r <= RST_S;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  assign speed_ref_o = s_r.spd;
  assign dir_cw_o = s_r.dir_cw;
  assign motor_enable_o = s_r.en;
  assign response_fast_o = s_r.resp_fast;
  assign torque_limit_pct_o = s_r.trq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence q_released;
    s_r.fsm == S_RUN && !fwd_q && !rev_q;
  endsequence

  sequence q_hold_run;
    s_r.fsm == S_RUN && one_run && ((fwd_q ^ dir_swap_i) == s_r.dir_cw);
  endsequence

  a_tgt_range: assert property ( // R1
    s_r.tgt == '0 || (s_r.tgt >= SPD_MIN && s_r.tgt <= SPD_MAX))
    else $error("speed command outside 0 or 100..4000");

  a_src_pick: assert property ( // R3
    src_q |=> s_r.tgt == $past(ext_spd))
    else $error("analogue source not taken when selected");

  a_dir_pick: assert property ( // R5
    s_r.fsm == S_IDLE && fwd_q && !rev_q |=> dir_cw_o == !$past(dir_swap_i) && motor_enable_o)
    else $error("forward run did not start in expected direction");

  a_both_stop: assert property ( // R7
    fwd_q && rev_q |=> speed_ref_o == '0 && !motor_enable_o)
    else $error("both run inputs did not stop instantly");

  a_instant_stop: assert property ( // R8
    q_released ##0 !stop_q |=> speed_ref_o == '0 && s_r.fsm == S_IDLE)
    else $error("instant stop not taken");

  a_decel_enter: assert property ( // R8
    q_released ##0 stop_q |=> s_r.fsm == S_DECEL && speed_ref_o == $past(speed_ref_o))
    else $error("ramped stop not entered");

  a_ramp_slope: assert property ( // R22
    q_hold_run |=> speed_ref_o == $past(speed_ref_o)
      || speed_ref_o == $past(speed_ref_o) + 12'h001
      || speed_ref_o + 12'h001 == $past(speed_ref_o))
    else $error("ramp changed by more than one step");

  a_step_space: assert property ( // R10
    step_w |=> !step_w)
    else $error("ramp steps on consecutive cycles");

  a_ramp_bounds: assert property ( // R9
    s_r.ramp_t >= RAMP_MIN_T && s_r.ramp_t <= RAMP_MAX_T)
    else $error("ramp time outside 0.2..15 s");

  a_decel_end: assert property ( // R22
    s_r.fsm == S_DECEL && speed_ref_o == '0 && !fwd_q && !rev_q |=> s_r.fsm == S_IDLE)
    else $error("deceleration did not end at zero");

  a_resp_hold: assert property ( // R13
    $past(s_r.resp_done) |-> $stable(response_fast_o))
    else $error("response mode changed after power-up");

  a_torque_cap: assert property ( // R16
    torque_limit_pct_o <= TRQ_MAX)
    else $error("torque limit above 200 percent");

endmodule

//--- sim/mrsc_ctrl_model.sv
/*
  Behavioural controller that drives the run and select pins.
  Assumes the bench calls drive() and HOLD is the scaled 10 ms.
*/
`timescale 1ns/1ns
module mrsc_ctrl_model #(
  parameter int HOLD = 16
) (
  input wire logic mclk_i,
  input wire logic polarity_i,
  output logic fwd_pin_o,
  output logic rev_pin_o,
  output logic stop_pin_o,
  output logic src_pin_o
);
  logic fwd_on = 1'b0;
  logic rev_on = 1'b0;
  logic stop_on = 1'b0;
  logic src_on = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // Source mode flips every pin, so levels follow the switch live
  assign fwd_pin_o = fwd_on ^ polarity_i;
  assign rev_pin_o = rev_on ^ polarity_i;
  assign stop_pin_o = stop_on ^ polarity_i;
  assign src_pin_o = src_on ^ polarity_i;

  //////////////////////////////////////////////////////////////////////////
  // One request; a direct reversal gets an idle gap first
  task automatic drive(input logic f, input logic r, input logic s, input logic m);
    if ((fwd_on && r && !f) || (rev_on && f && !r)) begin
      @(posedge mclk_i);
      #2;
      fwd_on = 1'b0;
      rev_on = 1'b0;
      repeat (HOLD) @(posedge mclk_i);
    end
    @(posedge mclk_i);
    #2;
    fwd_on = f;
    rev_on = r;
    stop_on = s;
    src_on = m;
    repeat (HOLD) @(posedge mclk_i);
    #2;
  endtask
endmodule

//--- sim/mrsc_top_tb.sv
/*
  Self-checking bench for the run/stop/speed command logic.
  Assumes short filter and ramp-unit parameters; knobs driven as codes.
*/
`timescale 1ns/1ns
module mrsc_top_tb;
  import mrsc_pkg::*;
  localparam int UNIT = 4000;
  localparam int LIMIT = 60000;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic pol = 1'b0;
  logic range_sw = 1'b0;
  logic resp_sw = 1'b1;
  logic swap = 1'b0;
  logic [11:0] knob = 12'h0C8;
  logic [11:0] ana = 12'h096;
  logic [7:0] ramp_k = 8'h00;
  logic [7:0] trq_k = 8'hFF;
  logic forward_run, reverse_run, stp, src, cw, en, fast;
  logic [11:0] spd;
  logic [7:0] trq;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int k;

  //////////////////////////////////////////////////////////////////////////
  // Clock, partner and design
  always #25 mclk_i = ~mclk_i;
  mrsc_ctrl_model #(.HOLD(16)) ctl (.mclk_i(mclk_i), .polarity_i(pol), .fwd_pin_o(forward_run),
    .rev_pin_o(reverse_run), .stop_pin_o(stp), .src_pin_o(src));
  mrsc_top #(.DEB_CYCLES(8), .RAMP_UNIT_CYCLES(UNIT)) dut (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .forward_run_i(forward_run), .reverse_run_i(reverse_run),
    .stop_style_select_i(stp), .speed_source_select_i(src), .input_polarity_switch_i(pol),
    .analog_range_switch_i(range_sw), .response_mode_switch_i(resp_sw), .dir_swap_i(swap),
    .internal_speed_knob_i(knob), .analog_speed_in_i(ana), .ramp_time_knob_i(ramp_k),
    .torque_limit_knob_i(trq_k), .speed_ref_o(spd), .dir_cw_o(cw), .motor_enable_o(en),
    .response_fast_o(fast), .torque_limit_pct_o(trq));

  //////////////////////////////////////////////////////////////////////////
  // Compare and wait helpers
  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bad(input string msg);
    err_total++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask
  task automatic chk_num(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) bad($sformatf("number %0d, expected %0d", got, exp));
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) bad($sformatf("flag %b, expected %b", got, exp));
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) bad($sformatf("cycles %0d, expected %0d..%0d", got, lo, hi));
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask
  task automatic wait_spd(input logic [11:0] v);
    k = 0;
    while (spd !== v && k < 24000) begin
      step(1);
      k++;
    end
  endtask
  task automatic wait_en(input logic v);
    k = 0;
    while (en !== v && k < 700) begin
      step(1);
      k++;
    end
  endtask
  // Slope: 3000 r/min per tenths*UNIT cycles, from wherever the ramp now is
  task automatic ramp_chk(input logic [11:0] tgt, input int tenths);
    int s0;
    int e;
    // Start counting on a step edge so the phase within one step drops out
    s0 = int'(spd);
    k = 0;
    while (int'(spd) == s0 && k < 24000) begin
      step(1);
      k++;
    end
    s0 = int'(spd);
    wait_spd(tgt);
    e = ((s0 > int'(tgt)) ? s0 - int'(tgt) : int'(tgt) - s0) * tenths * UNIT / 3000;
    chk_rng(k, e - 4, e + 4);
    chk_num(spd, tgt);
  endtask
  task automatic do_reset(input logic resp);
    reset_n_i = 1'b0;
    resp_sw = resp;
    step(3);
    chk_num(spd, 12'h000);
    chk_flag(en, 1'b0);
    reset_n_i = 1'b1;
    step(2);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad("run exceeded its cycle budget");
      conclude();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    do_reset(1'b1);
    chk_num(trq, 12'h0C8);
    chk_flag(fast, 1'b1);
    trq_k = 8'h80;
    step(3);
    chk_num(trq, 12'h064);
    trq_k = 8'h00;
    step(3);
    chk_num(trq, 12'h000);
    $display("test torque done");
    ctl.drive(1'b1, 1'b0, 1'b1, 1'b0);
    chk_flag(cw, 1'b1);
    ramp_chk(12'h0C8, 2);
    step(30);
    chk_num(spd, 12'h0C8);
    ctl.drive(1'b0, 1'b0, 1'b1, 1'b0);
    chk_flag(en, 1'b1);
    ramp_chk(12'h000, 2);
    step(2);
    chk_flag(en, 1'b0);
    $display("test ramped stop done");
    ctl.drive(1'b0, 1'b1, 1'b0, 1'b0);
    chk_flag(cw, 1'b0);
    wait_spd(12'h0C8);
    ctl.drive(1'b0, 1'b0, 1'b0, 1'b0);
    wait_en(1'b0);
    chk_num(spd, 12'h000);
    chk_rng(k, 0, 2);
    $display("test instant stop done");
    ctl.drive(1'b1, 1'b0, 1'b1, 1'b0);
    wait_spd(12'h0C8);
    ctl.drive(1'b1, 1'b1, 1'b1, 1'b0);
    wait_en(1'b0);
    chk_num(spd, 12'h000);
    chk_rng(k, 0, 2);
    ctl.drive(1'b0, 1'b0, 1'b1, 1'b0);
    $display("test both runs done");
    ctl.drive(1'b1, 1'b0, 1'b1, 1'b1);
    wait_spd(12'h12C);
    chk_num(spd, 12'h12C);
    range_sw = 1'b1;
    wait_spd(12'h096);
    chk_num(spd, 12'h096);
    ctl.drive(1'b1, 1'b0, 1'b1, 1'b0);
    wait_spd(12'h0C8);
    chk_num(spd, 12'h0C8);
    knob = 12'hFFF;
    wait_spd(12'hFA0);
    chk_num(spd, 12'hFA0);
    ctl.drive(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test sources done");
    knob = 12'h032;
    pol = 1'b1;
    swap = 1'b1;
    ctl.drive(1'b1, 1'b0, 1'b0, 1'b0);
    chk_flag(en, 1'b1);
    chk_flag(cw, 1'b0);
    step(50);
    chk_num(spd, 12'h000);
    ctl.drive(1'b0, 1'b0, 1'b0, 1'b0);
    pol = 1'b0;
    swap = 1'b0;
    $display("test polarity done");
    knob = 12'h064;
    ramp_k = 8'hFF;
    resp_sw = 1'b0;
    ctl.drive(1'b1, 1'b0, 1'b0, 1'b0);
    ramp_chk(12'h064, 150);
    chk_flag(fast, 1'b1);
    ctl.drive(1'b0, 1'b0, 1'b0, 1'b0);
    do_reset(1'b0);
    chk_flag(fast, 1'b0);
    $display("test slow ramp done");
    conclude();
  end
endmodule
